// >>> src/rcf_pkg.sv
// Constants for the reset-cause flags and brown-out control block
package rcf_pkg;
	// Bus and register widths
	localparam int DATA_W = 32;
	localparam int ADDR_W = 4;
	localparam int REG_W = 8;
	localparam int PIN_W = 4;

	// Byte offsets of the four registers
	localparam logic [ADDR_W-1:0] OFF_BCTL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CAUSE = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_MASK = 4'hc;

	// Brown-out control field positions
	localparam int B_SBEN = 7;
	localparam int B_RSVD = 6;
	localparam int B_RDY = 0;

	// Reset-cause flag positions, also used by event status and mask
	localparam int F_OVF = 7;
	localparam int F_UNF = 6;
	localparam int F_WDT = 4;
	localparam int F_PIN = 3;
	localparam int F_INSTR = 2;
	localparam int F_POR = 1;
	localparam int F_BOR = 0;

	// Write masks, reset values and brown-out update masks
	localparam logic [REG_W-1:0] BCTL_WMASK = 8'hc0;
	localparam logic [REG_W-1:0] BCTL_RST = 8'h80;
	localparam logic [REG_W-1:0] CAUSE_WMASK = 8'hdf;
	localparam logic [REG_W-1:0] CAUSE_POR_RST = 8'h1d;
	localparam logic [REG_W-1:0] BOR_SET = 8'h1c;
	localparam logic [REG_W-1:0] BOR_CLR = 8'hc1;
	localparam logic [REG_W-1:0] EV_MASK = 8'hdd;
	localparam logic [REG_W-1:0] MASK_RST = 8'h00;

	// Brown-out configuration field codes
	localparam logic [1:0] CFG_OFF = 2'h0;
	localparam logic [1:0] CFG_SW = 2'h1;
	localparam logic [1:0] CFG_NOSLP = 2'h2;
	localparam logic [1:0] CFG_ON = 2'h3;

	// Synchronised pin indices and their idle levels
	localparam int P_BOR = 0;
	localparam int P_LP = 1;
	localparam int P_PIN = 2;
	localparam int P_RDY = 3;
	localparam logic [PIN_W-1:0] PIN_RST = 4'h4;
endpackage

// >>> src/rcf_pin_if.sv
// Interface carrying raw pins into the synchroniser and filtered levels back
`timescale 1ns/1ps
interface rcf_pin_if;
	logic [rcf_pkg::PIN_W-1:0] raw;
	logic [rcf_pkg::PIN_W-1:0] level;
	modport src (output raw, input level);
	modport syn (input raw, output level);
endinterface

// >>> src/rcf_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rcf_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	rcf_pin_if.syn pins
);
	import rcf_pkg::*;

	logic [PIN_W-1:0] s1_reg;
	logic [PIN_W-1:0] s2_reg;
	logic [PIN_W-1:0] s3_reg;
	logic [PIN_W-1:0] level_reg;
	logic [PIN_W-1:0] level_next;

	// A bit only moves once stages two and three agree, so one-cycle glitches die here
	assign level_next = ((s2_reg ~^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & level_reg);
	assign pins.level = level_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= PIN_RST;
			s2_reg <= PIN_RST;
			s3_reg <= PIN_RST;
			level_reg <= PIN_RST;
		end else if (ce) begin
			s1_reg <= pins.raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end
endmodule

// >>> src/rcf_top.sv
// Reset-cause flags, brown-out control and event interrupt behind Avalon-MM
//
// Overview of operation
// R1: Config field 01 lets the software enable bit switch brown-out reset on/off.
// R2: Other config codes keep the enable bit read/write but without effect.
// R3: Enable bit is bit 7; loads 1 on power-on and brown-out, else kept.
// R4: Software keeps reserved bit 6 of brown-out control at zero.
// R5: Unimplemented bits read zero and ignore writes.
// R6: Bit 0 of brown-out control reads circuit-ready status, read-only.
// R7: A reset updates only the flag of its own cause; a brown-out here also loads flags 7, 6, 4, 3 and 2.
// R8: Hardware never restores a flag to inactive; software does that. A brown-out here returns flags 7, 6, 4, 3 and 2 to inactive.
// R9: Software writes to active level are stored and start no reset.
// R10: Bit 7 overflow flag set by hardware; cleared on power-on/brown-out.
// R11: Bit 6 underflow flag set by hardware; cleared on power-on/brown-out.
// R12: Bit 4 watchdog flag cleared by watchdog reset; 1 after power-on/brown-out.
// R13: Bit 3 pin flag cleared by pin reset; 1 after power-on/brown-out.
// R14: Bit 2 instruction flag cleared when reset instruction executes.
// R15: Bit 1 power-on flag cleared on power-on; software sets it afterwards.
// R16: Bit 0 brown-out flag cleared on brown-out; software sets it afterwards.
// R17: Either main or low-power detector clears the brown-out flag.
// R18: Stack events reset only with stack-reset enable; flags record regardless.
// R19: Reads return current values; writes land at a clock edge.
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rcf_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [rcf_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [rcf_pkg::DATA_W-1:0] avs_writedata,
	output logic [rcf_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [1:0] brownout_config_field,
	input wire logic stack_reset_enable,
	input wire logic supply_drop_detect,
	input wire logic low_power_supply_drop_detector,
	input wire logic external_reset_pin_n,
	input wire logic brownout_circuit_ready_in,
	input wire logic watchdog_timeout,
	input wire logic reset_instruction,
	input wire logic stack_overflow_event,
	input wire logic stack_underflow_event,
	output logic brownout_enable,
	output logic reset_request,
	output logic irq
);
	import rcf_pkg::*;

	rcf_pin_if pins ();

	logic wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [REG_W-1:0] bctl_reg;
	logic [REG_W-1:0] cause_reg;
	logic [REG_W-1:0] stat_reg;
	logic [REG_W-1:0] mask_reg;
	logic bor_en_reg;
	logic rst_req_reg;
	logic irq_reg;
	logic bor_prev_reg;
	logic lp_prev_reg;
	logic pin_prev_reg;

	// Analog detectors and the reset pin come from outside the clock domain
	assign pins.raw[P_BOR] = supply_drop_detect;
	assign pins.raw[P_LP] = low_power_supply_drop_detector;
	assign pins.raw[P_PIN] = external_reset_pin_n;
	assign pins.raw[P_RDY] = brownout_circuit_ready_in;

	rcf_sync u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.pins(pins.syn)
	);

	// Bus decode; a request is accepted while waitrequest is high
	wire req = avs_read | avs_write;
	wire accept = ce & req & wait_reg;
	wire commit = ce & req & ~wait_reg;
	wire sel_bctl = avs_address == OFF_BCTL;
	wire sel_cause = avs_address == OFF_CAUSE;
	wire sel_stat = avs_address == OFF_STAT;
	wire sel_mask = avs_address == OFF_MASK;
	wire wr_commit = commit & avs_write;
	wire wr_bctl = wr_commit & sel_bctl;
	wire wr_cause = wr_commit & sel_cause;
	wire wr_mask = wr_commit & sel_mask;
	wire rd_stat_clr = commit & avs_read & sel_stat;
	wire [REG_W-1:0] wdata = avs_writedata[REG_W-1:0];

	// Read view; ready bit is live, unimplemented bits read zero [R5] [R6] [R19]
	wire [REG_W-1:0] bctl_view = {bctl_reg[B_SBEN], bctl_reg[B_RSVD],
		{(B_RSVD-B_RDY-1){1'b0}}, pins.level[P_RDY]};
	wire [REG_W-1:0] rd_sel = sel_bctl ? bctl_view :
		sel_cause ? (cause_reg & CAUSE_WMASK) :
		sel_stat ? stat_reg :
		sel_mask ? mask_reg : '0;
	wire [DATA_W-1:0] rd_word = {{(DATA_W-REG_W){1'b0}}, rd_sel};

	// Edge detection on filtered levels only, never on the first sync stage
	wire bor_rise = pins.level[P_BOR] & ~bor_prev_reg;
	wire lp_rise = pins.level[P_LP] & ~lp_prev_reg;
	wire pin_fall = ~pins.level[P_PIN] & pin_prev_reg;

	// Main detector only counts while its circuit is enabled; low-power one always [R17]
	wire bor_evt = (bor_rise & bor_en_reg) | lp_rise;
	wire ovf_e = stack_overflow_event & ~bor_evt;
	wire unf_e = stack_underflow_event & ~bor_evt;
	wire wdt_e = watchdog_timeout & ~bor_evt;
	wire pin_e = pin_fall & ~bor_evt;
	wire instr_e = reset_instruction & ~bor_evt;

	// Effective brown-out enable from configuration field [R1] [R2]
	wire bor_en_next = (brownout_config_field == CFG_SW) ? bctl_reg[B_SBEN] :
		(brownout_config_field != CFG_OFF);

	// Software enable: brown-out forces 1, otherwise bus write or hold [R3]
	wire [REG_W-1:0] bctl_wr = wr_bctl ? (wdata & BCTL_WMASK) : bctl_reg;
	wire [REG_W-1:0] bctl_next = bor_evt ? (bctl_wr | BCTL_RST) : bctl_wr;

	// Hardware set/clear masks touch only the causing flag, but a brown-out loads every flag except bit 1 [R7] [R10] [R11]
	wire [REG_W-1:0] hw_set = bor_evt ? BOR_SET :
		((REG_W'(ovf_e) << F_OVF) | (REG_W'(unf_e) << F_UNF));
	// Active-low flags drop on their own cause [R12] [R13] [R14]
	wire [REG_W-1:0] hw_clr = bor_evt ? BOR_CLR :
		((REG_W'(wdt_e) << F_WDT) | (REG_W'(pin_e) << F_PIN) | (REG_W'(instr_e) << F_INSTR));
	// Software write first, hardware on top so a same-cycle event is not lost [R9]
	wire [REG_W-1:0] cause_wr = wr_cause ? (wdata & CAUSE_WMASK) : cause_reg;
	// No term drives a flag back to inactive except the bus write and a brown-out [R8] [R15] [R16]
	wire [REG_W-1:0] cause_next = (cause_wr | hw_set) & ~hw_clr;

	// Event status: read clears only the bits returned, new events win
	wire [REG_W-1:0] ev_vec = ((REG_W'(ovf_e) << F_OVF) | (REG_W'(unf_e) << F_UNF) |
		(REG_W'(wdt_e) << F_WDT) | (REG_W'(pin_e) << F_PIN) |
		(REG_W'(instr_e) << F_INSTR) | (REG_W'(bor_evt) << F_BOR)) & EV_MASK;
	wire [REG_W-1:0] stat_clr = rd_stat_clr ? rdata_reg[REG_W-1:0] : '0;
	wire [REG_W-1:0] stat_next = (stat_reg & ~stat_clr) | ev_vec;
	wire [REG_W-1:0] mask_next = wr_mask ? (wdata & EV_MASK) : mask_reg;
	wire irq_next = |(stat_next & mask_next);

	// Stack events reset only when enabled; flag writes never reset [R18] [R9]
	wire stack_rst = (ovf_e | unf_e) & stack_reset_enable;
	wire rst_req_next = bor_evt | wdt_e | pin_e | instr_e | stack_rst;

	// Bus handshake: one wait cycle, read data captured at accept
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else if (ce) begin
			wait_reg <= ~accept;
			if (accept & avs_read) begin
				rdata_reg <= rd_word;
			end
		end
	end

	// Control and flag registers; rst is the power-on reset [R3] [R10] [R15]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bctl_reg <= BCTL_RST;
			cause_reg <= CAUSE_POR_RST;
			stat_reg <= '0;
			mask_reg <= MASK_RST;
		end else if (ce) begin
			bctl_reg <= bctl_next;
			cause_reg <= cause_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
		end
	end

	// Outputs and edge history; brown-out circuit off until first evaluation
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bor_en_reg <= 1'b0;
			rst_req_reg <= 1'b0;
			irq_reg <= 1'b0;
			bor_prev_reg <= 1'b0;
			lp_prev_reg <= 1'b0;
			pin_prev_reg <= 1'b1;
		end else if (ce) begin
			bor_en_reg <= bor_en_next;
			rst_req_reg <= rst_req_next;
			irq_reg <= irq_next;
			bor_prev_reg <= pins.level[P_BOR];
			lp_prev_reg <= pins.level[P_LP];
			pin_prev_reg <= pins.level[P_PIN];
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign brownout_enable = bor_en_reg;
	assign reset_request = rst_req_reg;
	assign irq = irq_reg;

	// Sequence of an accepted brown-out
	sequence s_bor_seen;
		ce && bor_evt;
	endsequence

	property p_sw_enable;
		@(posedge clk) disable iff (rst)
		(ce && brownout_config_field == CFG_SW) |=> (brownout_enable == $past(bctl_reg[B_SBEN]));
	endproperty
	a_sw_enable: assert property (p_sw_enable) else $error("sw enable not followed"); // [R1]

	property p_cfg_ignore;
		@(posedge clk) disable iff (rst)
		(ce && brownout_config_field != CFG_SW) |=>
			(brownout_enable == ($past(brownout_config_field) != CFG_OFF));
	endproperty
	a_cfg_ignore: assert property (p_cfg_ignore) else $error("enable bit leaked"); // [R2]

	property p_bor_enable_set;
		@(posedge clk) disable iff (rst)
		s_bor_seen |=> bctl_reg[B_SBEN] && !cause_reg[F_BOR] && cause_reg[F_WDT];
	endproperty
	a_bor_enable_set: assert property (p_bor_enable_set) else $error("brown-out values"); // [R3]

	property p_unimpl_zero;
		@(posedge clk) disable iff (rst)
		(ce && accept && avs_read && sel_bctl) |=> (avs_readdata[B_RSVD-1:B_RDY+1] == '0);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits"); // [R5]

	property p_ovf_set;
		@(posedge clk) disable iff (rst)
		(ce && ovf_e) |=> cause_reg[F_OVF] && stat_reg[F_OVF];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set"); // [R10]

	property p_wdt_clear;
		@(posedge clk) disable iff (rst)
		(ce && wdt_e && !pin_e && !wr_cause) |=> !cause_reg[F_WDT] &&
			(cause_reg[F_PIN] == $past(cause_reg[F_PIN]));
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog flag"); // [R12]

	property p_flag_sticky;
		@(posedge clk) disable iff (rst)
		(ce && !wr_cause && !bor_evt && cause_reg[F_OVF]) |=> cause_reg[F_OVF];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped"); // [R8]

	property p_lp_bor;
		@(posedge clk) disable iff (rst)
		(ce && lp_rise) |=> !cause_reg[F_BOR] ##1 1'b1;
	endproperty
	a_lp_bor: assert property (p_lp_bor) else $error("low-power drop missed"); // [R17]

	property p_stack_noreset;
		@(posedge clk) disable iff (rst)
		(ce && !stack_reset_enable && !bor_evt && !wdt_e && !pin_e && !instr_e)
			|=> !reset_request;
	endproperty
	a_stack_noreset: assert property (p_stack_noreset) else $error("spurious reset"); // [R18]

	property p_write_active;
		@(posedge clk) disable iff (rst)
		(wr_cause && wdata[F_WDT] == 1'b0 && !wdt_e && !bor_evt) |=> !cause_reg[F_WDT];
	endproperty
	a_write_active: assert property (p_write_active) else $error("write not stored"); // [R9]

	property p_one_wait;
		@(posedge clk) disable iff (rst)
		(accept) |=> !avs_waitrequest ##1 (avs_waitrequest || !ce);
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait cycle count"); // [R19]

	// Register reads in two steps: accept with the address, then data on the bus
	sequence s_read_bctl;
		accept && avs_read && sel_bctl;
	endsequence

	sequence s_read_cause;
		accept && avs_read && sel_cause;
	endsequence

	// The ready bit is the live filtered pin, never a stored copy
	property p_ready_view;
		@(posedge clk) disable iff (rst)
		s_read_bctl |=> (avs_readdata[B_RDY] == $past(pins.level[P_RDY]));
	endproperty
	a_ready_view: assert property (p_ready_view) else $error("ready bit view"); // [R6]

	// Flag reads never show the hole at bit 5 or anything above the byte
	property p_cause_gap;
		@(posedge clk) disable iff (rst)
		s_read_cause |=> !avs_readdata[F_UNF-1] && (avs_readdata[DATA_W-1:REG_W] == '0);
	endproperty
	a_cause_gap: assert property (p_cause_gap) else $error("flag hole not zero"); // [R5]

	property p_unf_set;
		@(posedge clk) disable iff (rst)
		(ce && unf_e) |=> cause_reg[F_UNF] && stat_reg[F_UNF];
	endproperty
	a_unf_set: assert property (p_unf_set) else $error("underflow flag not set"); // [R11]

	property p_pin_clear;
		@(posedge clk) disable iff (rst)
		(ce && pin_e) |=> !cause_reg[F_PIN] && stat_reg[F_PIN];
	endproperty
	a_pin_clear: assert property (p_pin_clear) else $error("pin flag not cleared"); // [R13]

	property p_instr_clear;
		@(posedge clk) disable iff (rst)
		(ce && instr_e) |=> !cause_reg[F_INSTR] && stat_reg[F_INSTR];
	endproperty
	a_instr_clear: assert property (p_instr_clear) else $error("instruction flag"); // [R14]

	// An instruction reset alone leaves every other flag where it was
	property p_only_cause;
		@(posedge clk) disable iff (rst)
		(ce && instr_e && !wr_cause && !(wdt_e || pin_e || ovf_e || unf_e)) |=>
			({cause_reg[REG_W-1:F_INSTR+1], cause_reg[F_INSTR-1:0]} ==
			$past({cause_reg[REG_W-1:F_INSTR+1], cause_reg[F_INSTR-1:0]}));
	endproperty
	a_only_cause: assert property (p_only_cause) else $error("other flag moved"); // [R7]

	property p_stack_reset;
		@(posedge clk) disable iff (rst)
		(ce && stack_reset_enable && (ovf_e || unf_e)) |=> reset_request;
	endproperty
	a_stack_reset: assert property (p_stack_reset) else $error("stack reset missing"); // [R18]

	property p_bor_stack_clear;
		@(posedge clk) disable iff (rst)
		s_bor_seen |=> !cause_reg[F_OVF] && !cause_reg[F_UNF] && cause_reg[F_PIN];
	endproperty
	a_bor_stack_clear: assert property (p_bor_stack_clear) else $error("stack flags kept"); // [R10]

	// Main detector, once enabled, drops the brown-out flag like the low-power one
	property p_main_bor;
		@(posedge clk) disable iff (rst)
		(ce && bor_rise && bor_en_reg) |=> !cause_reg[F_BOR] && stat_reg[F_BOR];
	endproperty
	a_main_bor: assert property (p_main_bor) else $error("main drop missed"); // [R16]

	// A disabled main detector must leave the brown-out flag alone
	property p_main_ignored;
		@(posedge clk) disable iff (rst)
		(ce && bor_rise && !bor_en_reg && !lp_rise && !wr_cause) |=>
			(cause_reg[F_BOR] == $past(cause_reg[F_BOR]));
	endproperty
	a_main_ignored: assert property (p_main_ignored) else $error("disabled drop seen"); // [R1]

	// No hardware path touches the power-on flag; only a bus write or power-on does
	property p_por_kept;
		@(posedge clk) disable iff (rst)
		(ce && !wr_cause) |=> (cause_reg[F_POR] == $past(cause_reg[F_POR]));
	endproperty
	a_por_kept: assert property (p_por_kept) else $error("power-on flag moved"); // [R15]
endmodule

// >>> tb/reset_cause_flags_and_brownout_ctrl_tb.sv
// Self-checking bench for the reset-cause flags and brown-out control block
`timescale 1ns/1ps
module reset_cause_flags_and_brownout_ctrl_tb;
	import rcf_pkg::*;
	logic clk, rst, ce, avs_read, avs_write, avs_waitrequest, irq, reset_request, brownout_enable;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, r;
	logic [1:0] cfg;
	logic sre, main_det, lp_det, pin_n, rdy;
	logic [3:0] ev;
	logic [DATA_W-1:0] exp_q[$];
	logic [REG_W-1:0] flags_exp;
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 28799;
	int pos[4] = '{F_OVF, F_UNF, F_INSTR, F_WDT};

	rcf_top dut (.clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.brownout_config_field(cfg), .stack_reset_enable(sre), .supply_drop_detect(main_det),
		.low_power_supply_drop_detector(lp_det), .external_reset_pin_n(pin_n),
		.brownout_circuit_ready_in(rdy), .watchdog_timeout(ev[3]), .reset_instruction(ev[2]),
		.stack_overflow_event(ev[0]), .stack_underflow_event(ev[1]),
		.brownout_enable(brownout_enable), .reset_request(reset_request), .irq(irq));

	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string m);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask

	task print_verdict();
		$display("Mismatches %0d, comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// One Avalon transfer; request held until waitrequest is sampled low
	task bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		@(posedge clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		// Only the bench watchdog ends a wait that never sees waitrequest low
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Reads note their expected value; the monitor below compares it
	task rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] e);
		exp_q.push_back({24'h000000, e});
		bus(1'b0, a, 8'h00);
	endtask

	task wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
		bus(1'b1, a, d);
	endtask

	task wait_check_irq_low();
		repeat (2) @(posedge clk);
		@(negedge clk) check(32'(irq), 32'h0, "irq after status read");
	endtask

	// Read data stand at the edge where waitrequest is low
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			check(avs_readdata, exp_q.size() ? exp_q.pop_front() : 'x, "read data");
		end
	end

	// Cut a hang short well beyond the expected run of a few hundred cycles
	initial begin
		#1000000;
		bad_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		rst = 1'b1; ce = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = '0;
		avs_writedata = '0; cfg = 2'h1; sre = 1'b0; main_det = 1'b0; lp_det = 1'b0;
		pin_n = 1'b1; rdy = 1'b1; ev = 4'h0; r = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		flags_exp = CAUSE_POR_RST;
		rd(OFF_BCTL, BCTL_RST | 8'h01);
		rd(OFF_CAUSE, flags_exp);
		rd(OFF_STAT, 8'h00);
		rd(OFF_MASK, MASK_RST);
		// Reserved bit kept at zero; unimplemented bits must not stick
		wr(OFF_BCTL, 8'h3e);
		rd(OFF_BCTL, 8'h01);
		rd(4'h2, 8'h00);
		wr(OFF_STAT, 8'hff);
		rd(OFF_STAT, 8'h00);
		// Every configuration code against both enable values and ready levels
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 2; s++) begin
				cfg <= 2'(c);
				rdy <= s[0];
				wr(OFF_BCTL, {s[0], 7'h00});
				repeat (8) @(posedge clk);
				@(negedge clk) check(32'(brownout_enable), 32'((c == 1) ? s[0] : (c >= 2)), "enable");
				rd(OFF_BCTL, {s[0], 6'h00, s[0]});
			end
		end
		// Pulse events without, then with, stack reset and interrupt mask
		for (int p = 0; p < 2; p++) begin
			@(posedge clk) sre <= p[0];
			if (p == 1) begin
				wr(OFF_MASK, EV_MASK);
				rd(OFF_MASK, EV_MASK);
			end
			for (int i = 0; i < 4; i++) begin
				@(posedge clk) ev[i] <= 1'b1;
				@(posedge clk) ev[i] <= 1'b0;
				@(negedge clk) check(32'(reset_request), 32'((i >= 2) || p == 1), "reset request");
				check(32'(irq), 32'(p), "irq raise");
				flags_exp[pos[i]] = (i < 2);
				rd(OFF_CAUSE, flags_exp);
				rd(OFF_STAT, 8'h01 << pos[i]);
				wait_check_irq_low();
			end
		end
		// External pin held low long enough to pass the filter
		pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		pin_n <= 1'b1;
		repeat (8) @(posedge clk);
		flags_exp[F_PIN] = 1'b0;
		rd(OFF_CAUSE, flags_exp);
		rd(OFF_STAT, 8'h08);
		wait_check_irq_low();
		// Software may set flags either way without starting a reset
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			wr(OFF_CAUSE, r[7:0]);
			@(negedge clk) check(32'(reset_request), 32'h0, "no reset on write");
			flags_exp = r[7:0] & CAUSE_WMASK;
			rd(OFF_CAUSE, flags_exp);
		end
		// Main detector ignored while disabled; low-power detector always counts
		cfg <= 2'h1;
		wr(OFF_BCTL, 8'h00);
		main_det <= 1'b1;
		repeat (6) @(posedge clk);
		main_det <= 1'b0;
		repeat (8) @(posedge clk);
		rd(OFF_CAUSE, flags_exp);
		rd(OFF_STAT, 8'h00);
		lp_det <= 1'b1;
		repeat (6) @(posedge clk);
		lp_det <= 1'b0;
		repeat (8) @(posedge clk);
		flags_exp = (flags_exp & ~BOR_CLR) | BOR_SET;
		rd(OFF_CAUSE, flags_exp);
		rd(OFF_BCTL, 8'h81);
		rd(OFF_STAT, 8'h01);
		@(negedge clk) check(32'(brownout_enable), 32'h1, "enable after brown-out");
		// Main detector now enabled must also record a brown-out
		wr(OFF_CAUSE, 8'h00);
		main_det <= 1'b1;
		repeat (6) @(posedge clk);
		main_det <= 1'b0;
		repeat (8) @(posedge clk);
		rd(OFF_CAUSE, BOR_SET);
		// Power-on again in mid-run: stack flags drop, enable and flags take power-on values
		wr(OFF_CAUSE, 8'hc2);
		wr(OFF_BCTL, 8'h00);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		rd(OFF_CAUSE, CAUSE_POR_RST);
		rd(OFF_BCTL, BCTL_RST | 8'h01);
		rd(OFF_STAT, 8'h00);
		repeat (4) @(posedge clk);
		print_verdict();
	end
endmodule
